// >>> hw/pmc_pkg.sv
package pmc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [5:0] PMC_PORT_STRIDE   = 6'h10;
	localparam logic [5:0] PMC_OFF_MASTER    = 6'h00;
	localparam logic [5:0] PMC_OFF_PORT1_MDC = 6'h10;
	localparam logic [5:0] PMC_OFF_PORT2_MDC = 6'h20;
	localparam logic [5:0] PMC_OFF_MDC2_P1   = 6'h14;
	localparam logic [5:0] PMC_OFF_MDC2_P2   = 6'h24;
	localparam logic [5:0] PMC_OFF_PORT_MODE = 6'h00;
	localparam int         PMC_ADDR_W        = 6;
	localparam int         PMC_NUM_PORTS     = 2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PMC_BIT_TX_PD   = 7;
	localparam int PMC_BIT_RX_PD   = 6;
	localparam int PMC_BIT_PCLK    = 5;
	localparam int PMC_BIT_SERIAL_IF_MODE_HI = 4;
	localparam int PMC_BIT_SERIAL_IF_MODE_LO = 3;
	localparam int PMC_BIT_MON     = 2;
	localparam int PMC_BIT_PAR     = 5;
	localparam int PMC_BIT_SOFT_RESET_BIT    = 0;
	localparam int PMC_BIT_CMI     = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PMC_MDC_RST_FIXED = 8'h00;
	localparam logic [7:0] PMC_MASTER_RST    = 8'h00;
	localparam logic       PMC_CMI_RST       = 1'b1;

	// ----------------------------------------------------------------
	// Serial modes and strap encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PMC_SERIAL_IF_MODE_FIFO   = 2'h0,
		PMC_SERIAL_IF_MODE_PLESIO = 2'h1,
		PMC_SERIAL_IF_MODE_CDRFF  = 2'h2,
		PMC_SERIAL_IF_MODE_LOOP   = 2'h3
	} pmc_serial_if_mode_t;

	typedef enum logic [1:0] {
		PMC_STRAP_LOW   = 2'h0,
		PMC_STRAP_HIGH  = 2'h1,
		PMC_STRAP_FLOAT = 2'h2
	} pmc_strap_t;

	localparam logic [1:0] PMC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;

endpackage

// >>> hw/pmc_sync2.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser for strap pins
// ----------------------------------------------------------------
module pmc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

// >>> hw/pmc_path_ctrl.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Per-port transmit path steering from mode fields
// ----------------------------------------------------------------
module pmc_path_ctrl
	import pmc_pkg::*;
(
	input  wire logic       par_sel_i,
	input  wire logic [1:0] serial_if_mode_i,
	input  wire logic       pclk_mode_i,
	input  wire logic       tx_pd_i,
	input  wire logic       rx_pd_i,
	input  wire logic       mon_i,
	input  wire logic       cmi_i,
	output logic            fifo_en_o,
	output logic            cdr_en_o,
	output logic            loop_time_o,
	output logic            tx_oe_o,
	output logic            rx_en_o,
	output logic            mon_gain_o,
	output logic            pclk_out_en_o
);
	always_comb begin
		fifo_en_o   = 1'b1;
		cdr_en_o    = 1'b0;
		loop_time_o = 1'b0;
		if (par_sel_i) begin
			loop_time_o = (serial_if_mode_i == PMC_SERIAL_IF_MODE_LOOP);
		end else begin
			unique case (pmc_serial_if_mode_t'(serial_if_mode_i))
				PMC_SERIAL_IF_MODE_FIFO: begin
					fifo_en_o = 1'b1;
				end
				PMC_SERIAL_IF_MODE_PLESIO: begin
					fifo_en_o = 1'b0;
					cdr_en_o  = 1'b1;
				end
				PMC_SERIAL_IF_MODE_CDRFF: begin
					cdr_en_o = 1'b1;
				end
				PMC_SERIAL_IF_MODE_LOOP: begin
					loop_time_o = 1'b1;
				end
			endcase
		end
	end

	assign tx_oe_o       = !tx_pd_i;
	assign rx_en_o       = !rx_pd_i;
	assign mon_gain_o    = mon_i && cmi_i && !rx_pd_i;
	assign pclk_out_en_o = par_sel_i && pclk_mode_i;
endmodule

// >>> hw/pmc_top.sv
// Behaviour
// - Transmitter power-down bit 7 set tri-states the coded transmit output; clear runs it normally.
// - With the serial interface selected, the parallel clock mode bit is forced to read as one.
// - In parallel operation, clock mode 0 takes the transmit clock in, 1 generates and drives it out.
// - The parallel clock mode default comes from a strap captured at power-up or reset.
// - Serial mode 00 passes synchronous clock and data through the FIFO and bypasses recovery.
// - Serial mode 01 recovers a clock from plesiochronous data and bypasses the FIFO.
// - Serial mode 10 routes synchronous data through recovery and then the FIFO.
// - Serial mode 11 enables loop timing from the recovered receive clock.
// - With the parallel interface, only serial mode 11 has effect, enabling loop timing.
// - The serial mode default follows the clock-mode strap: low 00, float 11, high 01.
// - The receive monitor bit applies flat gain ahead of equalisation; clear is normal.
// - Monitor gain is only available with the coded coaxial line interface.
// - Global interface select bit 5 picks serial (0) or 4-bit parallel (1).
// - Only port addresses 1 and 2 hold port registers; higher ports are ignored.
// - Soft reset returns all registers to defaults and then clears itself.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module pmc_top
	import pmc_pkg::*;
(
	input  wire logic        CLOCK_I,
	input  wire logic        ARST_N_I,
	// AXI4-Lite slave
	input  wire logic [5:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [5:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	// Straps
	input  wire logic        PCLK_MODE_STRAP_I,
	input  wire logic [1:0]  CLOCK_MODE_STRAP_I,
	// Per-port steering, index 0 is port 1
	output logic [1:0]       TX_OE_O,
	output logic [1:0]       RX_EN_O,
	output logic [1:0]       MON_GAIN_O,
	output logic [1:0]       PAR_TX_CLK_OUT_EN_O,
	output logic [1:0]       TX_FIFO_EN_O,
	output logic [1:0]       TX_CDR_EN_O,
	output logic [1:0]       LOOP_TIMING_O,
	output logic             PARALLEL_IF_SELECT_O
);
	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	logic       pstrap_s;
	logic [1:0] cstrap_s;
	logic       reload_q;
	logic       soft_reset_q;

	pmc_sync2 #(.W(1)) u_sync_p (
		.clk_i    (CLOCK_I),
		.arst_n_i (ARST_N_I),
		.d_i      (PCLK_MODE_STRAP_I),
		.q_o      (pstrap_s)
	);
	pmc_sync2 #(.W(2)) u_sync_c (
		.clk_i    (CLOCK_I),
		.arst_n_i (ARST_N_I),
		.d_i      (CLOCK_MODE_STRAP_I),
		.q_o      (cstrap_s)
	);

	// Straps settle through the synchroniser before use; reload for three
	// cycles after release so the defaults come from stable pin levels.
	logic [1:0] reload_cnt_q;
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			reload_cnt_q <= 2'h0;
		end else if (reload_cnt_q != 2'h3) begin
			reload_cnt_q <= reload_cnt_q + 2'h1;
		end
	end
	assign reload_q = (reload_cnt_q != 2'h3) || soft_reset_q;

	function automatic logic [1:0] strap_serial_if_mode(input logic [1:0] s);
		unique case (pmc_strap_t'(s))
			PMC_STRAP_LOW:   strap_serial_if_mode = PMC_SERIAL_IF_MODE_FIFO;
			PMC_STRAP_FLOAT: strap_serial_if_mode = PMC_SERIAL_IF_MODE_LOOP;
			PMC_STRAP_HIGH:  strap_serial_if_mode = PMC_SERIAL_IF_MODE_PLESIO;
			default:         strap_serial_if_mode = PMC_SERIAL_IF_MODE_FIFO;
		endcase
	endfunction

	function automatic logic [7:0] mdc_default(input logic p, input logic [1:0] s);
		logic [7:0] v;
		v                                  = PMC_MDC_RST_FIXED;
		v[PMC_BIT_PCLK]                    = p;
		v[PMC_BIT_SERIAL_IF_MODE_HI:PMC_BIT_SERIAL_IF_MODE_LO] = strap_serial_if_mode(s);
		mdc_default                        = v;
	endfunction

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [5:0]  aw_addr_q;
	logic [7:0]  w_data_q;
	logic        w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        wr_fire;
	logic        wr_ok;

	assign S_AXI_AWREADY_O = !aw_hold_q && !bvalid_q;
	assign S_AXI_WREADY_O  = !w_hold_q && !bvalid_q;
	assign S_AXI_BVALID_O  = bvalid_q;
	assign S_AXI_BRESP_O   = bresp_q;
	assign wr_fire         = aw_hold_q && w_hold_q && !bvalid_q;

	function automatic logic addr_ok(input logic [5:0] a);
		addr_ok = (a == PMC_OFF_MASTER) || (a == PMC_OFF_PORT1_MDC) || (a == PMC_OFF_PORT2_MDC)
			|| (a == PMC_OFF_MDC2_P1) || (a == PMC_OFF_MDC2_P2);
	endfunction

	assign wr_ok = addr_ok(aw_addr_q);

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= 6'h00;
			w_data_q  <= 8'h00;
			w_strb_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= PMC_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_hold_q <= 1'b1;
				w_data_q <= S_AXI_WDATA_I[7:0];
				w_strb_q <= S_AXI_WSTRB_I[0];
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
			end else if (bvalid_q && S_AXI_BREADY_I) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] master_q;
	logic [7:0] mdc_q [PMC_NUM_PORTS];
	logic [1:0] cmi_q;
	logic       wr_en;

	assign wr_en = wr_fire && wr_ok && w_strb_q;

	// Soft reset bit never reads back set: it fires one reload cycle.
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= wr_en && (aw_addr_q == PMC_OFF_MASTER) && w_data_q[PMC_BIT_SOFT_RESET_BIT];
		end
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			master_q <= PMC_MASTER_RST;
		end else if (reload_q) begin
			master_q <= PMC_MASTER_RST;
		end else if (wr_en && aw_addr_q == PMC_OFF_MASTER) begin
			master_q                <= w_data_q;
			master_q[PMC_BIT_SOFT_RESET_BIT]  <= 1'b0;
		end
	end

	for (genvar p = 0; p < PMC_NUM_PORTS; p++) begin : g_port
		localparam logic [5:0] BASE = PMC_OFF_PORT1_MDC + 6'(p) * PMC_PORT_STRIDE;
		always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
			if (!ARST_N_I) begin
				mdc_q[p] <= PMC_MDC_RST_FIXED;
				cmi_q[p] <= PMC_CMI_RST;
			end else if (reload_q) begin
				mdc_q[p] <= mdc_default(pstrap_s, cstrap_s);
				cmi_q[p] <= PMC_CMI_RST;
			end else if (wr_en && aw_addr_q == BASE + PMC_OFF_PORT_MODE) begin
				mdc_q[p] <= w_data_q;
			end else if (wr_en && aw_addr_q == BASE + (PMC_OFF_MDC2_P1 - PMC_OFF_PORT1_MDC)) begin
				cmi_q[p] <= w_data_q[PMC_BIT_CMI];
			end
		end

		pmc_path_ctrl u_path (
			.par_sel_i     (master_q[PMC_BIT_PAR]),
			.serial_if_mode_i        (mdc_q[p][PMC_BIT_SERIAL_IF_MODE_HI:PMC_BIT_SERIAL_IF_MODE_LO]),
			.pclk_mode_i   (mdc_q[p][PMC_BIT_PCLK]),
			.tx_pd_i       (mdc_q[p][PMC_BIT_TX_PD]),
			.rx_pd_i       (mdc_q[p][PMC_BIT_RX_PD]),
			.mon_i         (mdc_q[p][PMC_BIT_MON]),
			.cmi_i         (cmi_q[p]),
			.fifo_en_o     (TX_FIFO_EN_O[p]),
			.cdr_en_o      (TX_CDR_EN_O[p]),
			.loop_time_o   (LOOP_TIMING_O[p]),
			.tx_oe_o       (TX_OE_O[p]),
			.rx_en_o       (RX_EN_O[p]),
			.mon_gain_o    (MON_GAIN_O[p]),
			.pclk_out_en_o (PAR_TX_CLK_OUT_EN_O[p])
		);
	end

	assign PARALLEL_IF_SELECT_O = master_q[PMC_BIT_PAR];

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	function automatic logic [7:0] mdc_view(input logic [7:0] r, input logic par);
		logic [7:0] v;
		v = r;
		if (!par) begin
			v[PMC_BIT_PCLK] = 1'b1;
		end
		mdc_view = v;
	endfunction

	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [7:0]  rbyte;
	logic        rok;

	assign S_AXI_ARREADY_O = !rvalid_q;
	assign S_AXI_RVALID_O  = rvalid_q;
	assign S_AXI_RDATA_O   = rdata_q;
	assign S_AXI_RRESP_O   = rresp_q;

	always_comb begin
		rok   = addr_ok(S_AXI_ARADDR_I);
		rbyte = 8'h00;
		unique case (S_AXI_ARADDR_I)
			PMC_OFF_MASTER:    rbyte = master_q;
			PMC_OFF_PORT1_MDC: rbyte = mdc_view(mdc_q[0], master_q[PMC_BIT_PAR]);
			PMC_OFF_PORT2_MDC: rbyte = mdc_view(mdc_q[1], master_q[PMC_BIT_PAR]);
			PMC_OFF_MDC2_P1:   rbyte = {cmi_q[0], 7'h00};
			PMC_OFF_MDC2_P2:   rbyte = {cmi_q[1], 7'h00};
			default:           rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= PMC_RESP_OKAY;
		end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rbyte};
			rresp_q  <= rok ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
		end else if (rvalid_q && S_AXI_RREADY_I) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule

// >>> test/pmc_top_sva.sv
`timescale 1ns/1ps
module pmc_top_sva
	import pmc_pkg::*;
(
	input wire logic        CLOCK_I,
	input wire logic        ARST_N_I,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic [1:0]  MON_GAIN_O,
	input wire logic [1:0]  RX_EN_O,
	input wire logic [1:0]  PAR_TX_CLK_OUT_EN_O,
	input wire logic [1:0]  TX_FIFO_EN_O,
	input wire logic [1:0]  TX_CDR_EN_O,
	input wire logic [1:0]  LOOP_TIMING_O,
	input wire logic        PARALLEL_IF_SELECT_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!ARST_N_I);

	AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response not held");
	AST_R_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data not held");
	AST_R_LAT: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
		else $error("read answer late");
	AST_PCLK_PAR: assert property (PAR_TX_CLK_OUT_EN_O != 2'h0 |-> PARALLEL_IF_SELECT_O)
		else $error("clock driven out in serial mode");
	AST_PAR_PATH: assert property (PARALLEL_IF_SELECT_O |-> TX_CDR_EN_O == 2'h0 && TX_FIFO_EN_O == 2'h3)
		else $error("parallel path wrong");
	AST_LOOP: assert property (LOOP_TIMING_O[0] |-> TX_FIFO_EN_O[0] && !TX_CDR_EN_O[0])
		else $error("loop timing path wrong");
	AST_SER_BYPASS: assert property (!PARALLEL_IF_SELECT_O && !TX_FIFO_EN_O[0] |-> TX_CDR_EN_O[0] && !LOOP_TIMING_O[0])
		else $error("fifo bypass without recovery");
	AST_MON_RX: assert property (MON_GAIN_O[0] |-> RX_EN_O[0])
		else $error("gain on powered-down receiver");
endmodule

bind pmc_top pmc_top_sva pmc_top_sva_i (.CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
	.S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
	.S_AXI_RDATA_O(S_AXI_RDATA_O), .MON_GAIN_O(MON_GAIN_O), .RX_EN_O(RX_EN_O), .TX_CDR_EN_O(TX_CDR_EN_O),
	.PAR_TX_CLK_OUT_EN_O(PAR_TX_CLK_OUT_EN_O), .TX_FIFO_EN_O(TX_FIFO_EN_O), .LOOP_TIMING_O(LOOP_TIMING_O),
	.PARALLEL_IF_SELECT_O(PARALLEL_IF_SELECT_O));

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import pmc_pkg::*;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, pstrap;
	logic        awready, wready, bvalid, arready, rvalid, par_sel;
	logic [5:0]  awaddr, araddr;
	logic [3:0]  wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  cstrap, bresp, rresp, tx_oe, rx_en, mon, pclk_en, fifo_en, cdr_en, loop_t;
	int          miscompares, n_tests;

	pmc_top pmc_top_i (.CLOCK_I(clk), .ARST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .PCLK_MODE_STRAP_I(pstrap),
		.CLOCK_MODE_STRAP_I(cstrap), .TX_OE_O(tx_oe), .RX_EN_O(rx_en), .MON_GAIN_O(mon),
		.PAR_TX_CLK_OUT_EN_O(pclk_en), .TX_FIFO_EN_O(fifo_en), .TX_CDR_EN_O(cdr_en), .LOOP_TIMING_O(loop_t),
		.PARALLEL_IF_SELECT_O(par_sel));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk("bresp", 32'(bresp), 32'(er));
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				chk("rdata", rdata, ed);
				chk("rresp", 32'(rresp), 32'(er));
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults();
		rd(6'h10, 32'h38, PMC_RESP_OKAY);
		rd(6'h24, 32'h80, PMC_RESP_OKAY);
		chk("loop", 32'(loop_t), 32'h3);
	endtask

	task automatic t_parallel();
		wr(6'h00, 8'h20, PMC_RESP_OKAY);
		chk("par", 32'(par_sel), 32'h1);
		chk("pclk_en", 32'(pclk_en), 32'h3);
		for (int c = 0; c < 3; c++) begin
			wr(6'h10, 8'(c << 3), PMC_RESP_OKAY);
			chk("loop", 32'(loop_t), 32'h2);
			chk("pclk_en", 32'(pclk_en), 32'h2);
			rd(6'h10, 32'(c << 3), PMC_RESP_OKAY);
		end
		wr(6'h00, 8'h00, PMC_RESP_OKAY);
	endtask

	task automatic t_serial();
		logic [3:0] fe, ce, le;
		fe = 4'hD;
		ce = 4'h6;
		le = 4'h8;
		for (int c = 0; c < 4; c++) begin
			wr(6'h10, 8'(c << 3), PMC_RESP_OKAY);
			rd(6'h10, 32'(c << 3) | 32'h20, PMC_RESP_OKAY);
			chk("fifo", 32'(fifo_en[0]), 32'(fe[c]));
			chk("cdr", 32'(cdr_en[0]), 32'(ce[c]));
			chk("loop", 32'(loop_t[0]), 32'(le[c]));
		end
	endtask

	task automatic t_power();
		wr(6'h10, 8'hC4, PMC_RESP_OKAY);
		chk("tx_oe", 32'(tx_oe), 32'h2);
		chk("rx_en", 32'(rx_en), 32'h2);
		wr(6'h10, 8'h04, PMC_RESP_OKAY);
		chk("mon", 32'(mon), 32'h1);
		wr(6'h24, 8'h00, PMC_RESP_OKAY);
		wr(6'h20, 8'h04, PMC_RESP_OKAY);
		chk("mon", 32'(mon), 32'h1);
	endtask

	task automatic t_bad();
		wr(6'h30, 8'hFF, PMC_RESP_SLVERR);
		rd(6'h30, 32'h0, PMC_RESP_SLVERR);
		rd(6'h10, 32'h24, PMC_RESP_OKAY);
	endtask

	task automatic t_soft_reset_bit();
		wr(6'h00, 8'h21, PMC_RESP_OKAY);
		repeat (4) @(posedge clk);
		rd(6'h00, 32'h0, PMC_RESP_OKAY);
		rd(6'h10, 32'h38, PMC_RESP_OKAY);
		rd(6'h24, 32'h80, PMC_RESP_OKAY);
		chk("mon", 32'(mon), 32'h0);
		// Other strap levels, picked up by a soft reset
		cstrap <= PMC_STRAP_HIGH;
		wr(6'h00, 8'h01, PMC_RESP_OKAY);
		repeat (4) @(posedge clk);
		rd(6'h10, 32'h28, PMC_RESP_OKAY);
		chk("cdr", 32'(cdr_en), 32'h3);
		cstrap <= PMC_STRAP_LOW;
		wr(6'h00, 8'h01, PMC_RESP_OKAY);
		repeat (4) @(posedge clk);
		rd(6'h10, 32'h20, PMC_RESP_OKAY);
		chk("loop", 32'(loop_t), 32'h0);
	endtask

	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 44'h0;
		wstrb = 4'hF;
		pstrap = 1'b1;
		cstrap = PMC_STRAP_FLOAT;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Strap reload window overrides early writes
		repeat (4) @(posedge clk);
		t_defaults();
		t_parallel();
		t_serial();
		t_power();
		t_bad();
		t_soft_reset_bit();
		summarize();
	end

	initial begin
		#100000;
		miscompares++;
		summarize();
	end
endmodule
